// ### hdl/ebc_pkg.sv
// Package of constants and carrier types for the earth blanking counter.
// Summary of operation
// RULE1 - Count tachometer pulses in nine-bit register, max 511
// RULE2 - Each tachometer pulse is one degree; 360 per turn
// RULE3 - Clear count at 360 or sky-to-earth pulse
// RULE4 - Decode angle markers at counts 200 and 330
// RULE5 - Fine gain: blank sensor outputs from 0 to 330
// RULE6 - Coarse gain: blank 0 to 200, keep 330 backup
// RULE7 - Coarse gain when smoothed error exceeds threshold
// RULE8 - Ground commands route either sensor, cross-coupling allowed
// RULE9 - 200 marker resets error detector, fine mode only
// RULE10 - Pass pulses after deblank marker, reblank after clear
`default_nettype none
package ebc_pkg;
    localparam int          CNT_W        = 9;
    localparam logic [8:0]  CNT_MAX      = 9'h1ff;
    localparam logic [8:0]  CNT_REV      = 9'h168;
    localparam logic [8:0]  CNT_MARK_LO  = 9'h0c8;
    localparam logic [8:0]  CNT_MARK_HI  = 9'h14a;
    localparam logic [8:0]  CNT_RESET    = 9'h000;
    localparam int          ERR_W        = 12;

    typedef enum logic [1:0] {
        EBC_SEL_A     = 2'h0,
        EBC_SEL_B     = 2'h1,
        EBC_SEL_CROSS = 2'h2,
        EBC_SEL_NONE  = 2'h3
    } ebc_sel_t;

    // Raw pulse inputs from the threshold amplifiers and the encoder.
    typedef struct packed {
        logic tach;
        logic sens_a;
        logic sens_b;
    } ebc_pins_t;

    // Blanking outputs.
    typedef struct packed {
        logic sens_pass;
        logic detector_reset;
        logic mark_lo;
        logic mark_hi;
        logic coarse;
    } ebc_out_t;
endpackage : ebc_pkg
`default_nettype wire

// ### hdl/ebc_top.sv
// Earth blanking counter: angle count, markers, gain mode and sensor gating.
`default_nettype none
module ebc_top
(
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    // Pulse inputs from outside
    input  wire ebc_pkg::ebc_pins_t          pins,
    // Ground command sensor routing
    input  wire ebc_pkg::ebc_sel_t           sensor_sel,
    // Smoothed pitch error magnitude and preset threshold
    input  wire logic [ebc_pkg::ERR_W-1:0]   err_mag,
    input  wire logic [ebc_pkg::ERR_W-1:0]   err_thresh,
    // Results
    output logic [ebc_pkg::CNT_W-1:0]        angle_count,
    output ebc_pkg::ebc_out_t                outs
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers: three stages, a change counts once stages 2 and 3 agree.
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] sync3_reg;
    wire  [2:0] rise;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sync3_reg <= 3'h0;
        end
        else
        begin
            sync1_reg <= {pins.tach, pins.sens_a, pins.sens_b};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_level
            // Agreed level of this input; it starts low like an idle pin, so reset gives no false edge.
            logic level_reg;

            always_ff @(posedge sys_clk)
            begin
                if (rst)
                    level_reg <= 1'b0;
                else if (sync2_reg[gi] == sync3_reg[gi])
                    level_reg <= sync3_reg[gi];
            end

            // A pulse counts once, on the cycle its agreed level first turns high.
            assign rise[gi] = (sync2_reg[gi] == sync3_reg[gi]) && sync3_reg[gi] && !level_reg;
        end
    endgenerate

    // Rising-edge events, one per pin.
    logic tach_evt;
    logic sens_a_evt;
    logic sens_b_evt;
    assign tach_evt   = rise[2];
    assign sens_a_evt = rise[1];
    assign sens_b_evt = rise[0];

    ////////////////////////////////////////////////////////////////////////////
    // Ground command routing of the sensor threshold path.
    // The none setting cuts the path, so no sensor pulse can pass or clear the count.
    logic sens_evt;
    always_comb
    begin
        case (sensor_sel)
            ebc_pkg::EBC_SEL_A:     sens_evt = sens_a_evt; // RULE8
            ebc_pkg::EBC_SEL_B:     sens_evt = sens_b_evt; // RULE8
            ebc_pkg::EBC_SEL_CROSS: sens_evt = sens_a_evt | sens_b_evt; // RULE8
            default:                sens_evt = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gain mode from the error comparator.
    // The comparison is registered, so the gain mode follows the error one cycle late.
    logic coarse_reg;
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            coarse_reg <= 1'b0;
        else
            coarse_reg <= (err_mag > err_thresh); // RULE7
    end

    ////////////////////////////////////////////////////////////////////////////
    // Angle counter, one count per degree.
    logic [ebc_pkg::CNT_W-1:0] count_reg;
    logic [ebc_pkg::CNT_W-1:0] count_next;
    logic                      wrap_hit;
    logic                      sky_hit;
    logic                      clear;
    logic                      open_reg;

    // The pulse after count 359 completes the revolution and wraps to zero.
    assign wrap_hit = tach_evt && (count_reg == ebc_pkg::CNT_REV - 9'h001); // RULE2 RULE3

    // Sky-to-earth pulse is the first sensor pulse seen while deblanked.
    assign sky_hit = sens_evt && open_reg; // RULE3

    // Either event clears the count, whichever comes first.
    assign clear = wrap_hit || sky_hit; // RULE3

    // The count saturates at full capacity, although in use it wraps at 360 long before.
    always_comb
    begin
        if (clear)
            count_next = ebc_pkg::CNT_RESET; // RULE3
        else if (tach_evt && count_reg != ebc_pkg::CNT_MAX)
            count_next = count_reg + 9'h001; // RULE1 RULE2
        else
            count_next = count_reg;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            count_reg <= ebc_pkg::CNT_RESET;
        else
            count_reg <= count_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Markers and blanking window.
    // A clear wins over a marker in the same cycle, so every revolution starts blanked.
    // In coarse gain the 330 marker still opens the window as a backup.
    logic mark_lo;
    logic mark_hi;
    assign mark_lo = (count_reg == ebc_pkg::CNT_MARK_LO); // RULE4
    assign mark_hi = (count_reg == ebc_pkg::CNT_MARK_HI); // RULE4

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            open_reg <= 1'b0;
        else if (clear)
            open_reg <= 1'b0; // RULE10
        else if (mark_hi)
            open_reg <= 1'b1; // RULE5 RULE6 RULE10
        else if (mark_lo && coarse_reg)
            open_reg <= 1'b1; // RULE6 RULE10
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs, one flip-flop group per concern.
    logic pass_reg;
    logic det_reset_reg;
    logic mark_lo_reg;
    logic mark_hi_reg;
    logic coarse_out_reg;

    // A sensor pulse passes the blanking only when it also closes the window.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            pass_reg <= 1'b0;
        else
            pass_reg <= sky_hit; // RULE5 RULE6 RULE10
    end

    // Backup detector reset: the tachometer pulse that leaves count 200, fine gain only.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            det_reset_reg <= 1'b0;
        else
            det_reset_reg <= tach_evt && mark_lo && !coarse_reg; // RULE9
    end

    // Marker levels stand for as long as the count holds the marker value.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            mark_lo_reg <= 1'b0;
            mark_hi_reg <= 1'b0;
        end
        else
        begin
            mark_lo_reg <= mark_lo; // RULE4
            mark_hi_reg <= mark_hi; // RULE4
        end
    end

    // Gain mode as reported to the outside.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            coarse_out_reg <= 1'b0;
        else
            coarse_out_reg <= coarse_reg; // RULE7
    end

    // The reported angle lags the internal count by one cycle.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            angle_count <= ebc_pkg::CNT_RESET;
        else
            angle_count <= count_reg; // RULE1
    end

    assign outs = '{
        sens_pass:      pass_reg,
        detector_reset: det_reset_reg,
        mark_lo:        mark_lo_reg,
        mark_hi:        mark_hi_reg,
        coarse:         coarse_out_reg
    };

endmodule : ebc_top
`default_nettype wire

// ### verif/ebc_top_props.sv
// Concurrent checks on the earth blanking counter ports.
`default_nettype none
module ebc_top_props
(
    // Clock and reset
    input wire logic                      sys_clk,
    input wire logic                      rst,
    // Inputs
    input wire ebc_pkg::ebc_pins_t        pins,
    input wire ebc_pkg::ebc_sel_t         sensor_sel,
    input wire logic [ebc_pkg::ERR_W-1:0] err_mag,
    input wire logic [ebc_pkg::ERR_W-1:0] err_thresh,
    // Outputs
    input wire logic [ebc_pkg::CNT_W-1:0] angle_count,
    input wire ebc_pkg::ebc_out_t         outs
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence big_err; (err_mag > err_thresh)[*3]; endsequence
    sequence small_err; (err_mag <= err_thresh)[*3]; endsequence
    cnt_range_a: assert property (angle_count <= 9'h167) else $error("count range");
    cnt_step_a: assert property ($changed(angle_count) |->
        angle_count == $past(angle_count) + 9'h001 || angle_count == 9'h000) else $error("count step");
    mark_lo_a: assert property (outs.mark_lo == (angle_count == ebc_pkg::CNT_MARK_LO))
        else $error("mark lo");
    mark_hi_a: assert property (outs.mark_hi == (angle_count == ebc_pkg::CNT_MARK_HI))
        else $error("mark hi");
    fine_blank_a: assert property (outs.sens_pass && !$past(outs.coarse) |-> angle_count >= 9'h149)
        else $error("fine blank");
    coarse_blank_a: assert property (outs.sens_pass |-> angle_count >= 9'h0c7) else $error("blank");
    pass_clear_a: assert property (outs.sens_pass |-> ##[0:3] angle_count == 9'h000) else $error("clear");
    coarse_on_a: assert property (big_err |-> outs.coarse) else $error("coarse on");
    coarse_off_a: assert property (small_err |-> !outs.coarse) else $error("coarse off");
    det_fine_a: assert property (outs.detector_reset |-> !outs.coarse &&
        angle_count == ebc_pkg::CNT_MARK_LO) else $error("detector reset");
    sel_none_a: assert property ((sensor_sel == ebc_pkg::EBC_SEL_NONE)[*6] |-> !outs.sens_pass)
        else $error("sel none");
endmodule : ebc_top_props
`default_nettype wire

// ### verif/ebc_src.sv
// Model of the tachometer and sensor threshold pulse sources.
`default_nettype none
module ebc_src
(
    // Clock
    input  wire logic              sys_clk,
    // Pulses
    output var ebc_pkg::ebc_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pins = '0;
    task automatic pulse(input int i);
        @(negedge sys_clk) pins[i] = 1'b1;
        repeat (4) @(negedge sys_clk);
        pins[i] = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask : pulse
endmodule : ebc_src
`default_nettype wire

// ### verif/tb.sv
// Testbench for the earth blanking counter with a scoreboard queue.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    ebc_pkg::ebc_sel_t sensor_sel = ebc_pkg::EBC_SEL_A;
    logic [11:0] err_mag = 12'h000;
    logic [11:0] err_thresh = 12'h000;
    ebc_pkg::ebc_pins_t pins;
    ebc_pkg::ebc_out_t outs;
    logic [8:0] angle_count;
    logic [8:0] cnt = 9'h000;
    logic [8:0] last = 9'h000;
    logic [8:0] exp_q[$];
    int mismatches = 0;
    int samples_checked = 0;
    int a[4] = '{250, 199, 360, 340};
    int b[4] = '{80, 1, 0, 0};
    always #2.5 sys_clk = ~sys_clk;
    ebc_src src (.sys_clk(sys_clk), .pins(pins));
    ebc_top uut (.sys_clk(sys_clk), .rst(rst), .pins(pins), .sensor_sel(sensor_sel), .err_mag(err_mag),
        .err_thresh(err_thresh), .angle_count(angle_count), .outs(outs));
    always @(negedge sys_clk)
    begin
        if (!rst && angle_count !== last)
        begin
            samples_checked++;
            if (exp_q.size() == 0 || exp_q[0] !== angle_count)
            begin
                mismatches++;
                $display("MISMATCH angle_count exp %h seen %h", exp_q.size() ? exp_q[0] : 9'h1ff, angle_count);
            end
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
        last <= angle_count;
    end
    task automatic steps(input int n);
        repeat (n)
        begin
            cnt = (cnt == 9'h167) ? 9'h000 : cnt + 9'h001;
            exp_q.push_back(cnt);
            src.pulse(2);
        end
    endtask : steps
    task automatic hit(input int w);
        if ((sensor_sel == 2 || sensor_sel == w) && cnt != 9'h000 &&
            cnt >= (err_mag > err_thresh ? 9'h0c8 : 9'h14a))
        begin
            exp_q.push_back(9'h000);
            cnt = 9'h000;
        end
        src.pulse(1 - w);
    endtask : hit
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    initial
    begin
        #200us;
        mismatches++;
        results();
    end
    initial
    begin
        void'($urandom(32'h5634));
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        for (int t = 0; t < 4; t++)
        begin
            @(negedge sys_clk);
            sensor_sel = ebc_pkg::ebc_sel_t'(t == 3 ? 3 : $urandom_range(2, 0));
            err_thresh = 12'($urandom_range(4094, 1));
            err_mag = (t % 2 == 1) ? err_thresh + 12'h001 : err_thresh - 12'h001;
            repeat (4) @(negedge sys_clk);
            steps(a[t]);
            hit(0);
            hit(1);
            if (t == 3) sensor_sel = ebc_pkg::EBC_SEL_CROSS;
            steps(b[t]);
            hit(0);
            hit(1);
            $display("test %0d done", t);
        end
        repeat (10) @(negedge sys_clk);
        if (exp_q.size() != 0)
        begin
            mismatches++;
            $display("MISMATCH exp_q_size exp 0 seen %0d", exp_q.size());
        end
        results();
    end
endmodule : tb
bind ebc_top ebc_top_props props (.sys_clk(sys_clk), .rst(rst), .pins(pins), .sensor_sel(sensor_sel),
    .err_mag(err_mag), .err_thresh(err_thresh), .angle_count(angle_count), .outs(outs));
`default_nettype wire
